/* design/thermal_sensor_cfg.svh */
`ifndef THERMAL_SENSOR_CFG_SVH
`define THERMAL_SENSOR_CFG_SVH

// Register indices
`define TSR_CAP_IDX 3'h0
`define TSR_CFG_IDX 3'h1
`define TSR_UPPER_IDX 3'h2
`define TSR_LOWER_IDX 3'h3
`define TSR_CRIT_IDX 3'h4
`define TSR_TEMP_IDX 3'h5
`define TSR_MAKER_IDX 3'h6
`define TSR_PART_IDX 3'h7

// Reset and fixed values (identity values are arbitrary)
`define TSR_CAP_VALUE 16'h005f
`define TSR_CFG_RESET 16'h0000
`define TSR_LIMIT_RESET 16'h0000
`define TSR_TEMP_RESET 13'h0000
`define TSR_MAKER_VALUE 16'h00a5
`define TSR_PART_VALUE 16'h0001

// Configuration bit positions
`define CFG_MODE_BIT 0
`define CFG_POL_BIT 1
`define CFG_CRIT_ONLY_BIT 2
`define CFG_OUT_EN_BIT 3
`define CFG_STS_BIT 4
`define CFG_CLEAR_BIT 5
`define CFG_ALARM_LOCK_BIT 6
`define CFG_CRIT_LOCK_BIT 7
`define CFG_PWR_DOWN_BIT 8
`define CFG_TRIP_HYSTERESIS_LO 9
`define CFG_TRIP_HYSTERESIS_HI 10

// Capability bit positions
`define CAP_ALERT_PD_BIT 7

// Field masks
`define TEMP_VALUE_MASK 16'h1fff
`define LIMIT_VALUE_MASK 16'h1ffc

// Hysteresis in sixteenths of a degree: 0, 1.5, 3, 6
`define TRIP_HYSTERESIS_0 13'h0000
`define TRIP_HYSTERESIS_1 13'h0018
`define TRIP_HYSTERESIS_2 13'h0030
`define TRIP_HYSTERESIS_3 13'h0060

// Shortest time between conversions: 100 ms at 200 MHz
`define CONV_PERIOD_MS 100
`define CLK_MHZ 200
`define CONV_CYCLES (`CONV_PERIOD_MS * 1000 * `CLK_MHZ)

`endif

/* design/thermal_sensor_pkg.sv */
`default_nettype none

package thermal_sensor_pkg;

    // Host register access, one 16-bit word per request
    typedef struct packed {
        logic wr;
        logic rd;
        logic ptr_wr;
        logic [2:0] ptr;
        logic [15:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic [1:0] trip_hysteresis;
        logic power_down;
        logic crit_freeze;
        logic alarm_lock;
        logic alert_on;
        logic out_en;
        logic crit_only;
        logic polarity;
        logic intr_mode;
    } cfg_t;

    typedef struct packed {
        logic [2:0] ptr;
        cfg_t cfg;
        logic [15:0] upper;
        logic [15:0] lower;
        logic [15:0] crit;
        logic [12:0] temp;
        logic alarm_prev;
        logic [31:0] conv_cnt;
        logic [15:0] rdata;
        logic rvalid;
        logic alert_pin;
        logic alert_oe_n;
    } state_t;

endpackage : thermal_sensor_pkg

`default_nettype wire

/* design/thermal_sensor_register_bank.sv */
`include "thermal_sensor_cfg.svh"
`default_nettype none

// Contract
// - Eight 16-bit registers at 0x00..0x07
// - Pointer starts at capability register
// - Capability reads fixed, writes ignored
// - Resolution field encodes temperature step
// - Bit 7 reports power-down alert behaviour
// - Bit 6 reports bus timeout window
// - Hysteresis field widens limit trips
// - Power-down freezes temperature register
// - Power-down cannot be set while locked
// - Critical freeze blocks critical limit writes
// - Alarm lock blocks upper/lower limit writes
// - Locks freeze hysteresis, enable, polarity, mode
// - Critical-only mode; refused under alarm lock
// - Clear write drops latched interrupt event
// - Status bit copies alert, polarity independent
// - Disabled output inactive per polarity
// - Polarity bit selects asserted level
// - Compare temperature with limits for alert
// - Alert output disabled after power-up
// - Trip flags from raw comparisons
// - Temperature two's complement, 0.0625 step
// - Limits two's complement, 0.25 step
// - Comparator or latched interrupt mode
// - Critical at/above, high above, low below
module thermal_sensor_register_bank (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // Register access from the serial front end
    input wire thermal_sensor_pkg::reg_req_t req_i,
    // Converter result, signed sixteenths of a degree
    input wire logic [12:0] adc_temp_i,
    input wire logic adc_valid_i,
    // Read data
    output logic [15:0] rdata_o,
    output logic rvalid_o,
    output logic [2:0] ptr_o,
    // Alert pin: level and enable, enable low drives; open-drain when active low, driven to both levels when active high
    output logic alert_o,
    output logic alert_oe_n_o
);

    thermal_sensor_pkg::state_t s_r;
    thermal_sensor_pkg::state_t s_nxt;

    // Fixed capability word as a named value, so single bits can be selected
    localparam logic [15:0] cap_fixed = `TSR_CAP_VALUE;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic signed [13:0] sx(input logic [12:0] v);
        sx = {v[12], v};
    endfunction

    // limits keep only the quarter-degree bits
    function automatic logic [15:0] limit_word(input logic [15:0] v);
        limit_word = v & `LIMIT_VALUE_MASK;
    endfunction

    function automatic logic [12:0] trip_hysteresis_of(input logic [1:0] h);
        case (h)
            2'h1: trip_hysteresis_of = `TRIP_HYSTERESIS_1;
            2'h2: trip_hysteresis_of = `TRIP_HYSTERESIS_2;
            2'h3: trip_hysteresis_of = `TRIP_HYSTERESIS_3;
            default: trip_hysteresis_of = `TRIP_HYSTERESIS_0;
        endcase
    endfunction

    function automatic logic [15:0] cfg_word(input thermal_sensor_pkg::cfg_t c);
        cfg_word = '0;
        cfg_word[`CFG_TRIP_HYSTERESIS_HI:`CFG_TRIP_HYSTERESIS_LO] = c.trip_hysteresis;
        cfg_word[`CFG_PWR_DOWN_BIT] = c.power_down;
        cfg_word[`CFG_CRIT_LOCK_BIT] = c.crit_freeze;
        cfg_word[`CFG_ALARM_LOCK_BIT] = c.alarm_lock;
        cfg_word[`CFG_STS_BIT] = c.alert_on & c.out_en;
        cfg_word[`CFG_OUT_EN_BIT] = c.out_en;
        cfg_word[`CFG_CRIT_ONLY_BIT] = c.crit_only;
        cfg_word[`CFG_POL_BIT] = c.polarity;
        cfg_word[`CFG_MODE_BIT] = c.intr_mode;
    endfunction

    // ------------------------------------------------------------
    // Comparisons
    // ------------------------------------------------------------
    logic signed [13:0] t_s;
    logic signed [13:0] hy_s;
    logic above_crit;
    logic above_upper;
    logic below_lower;
    logic crit_hold;
    logic upper_hold;
    logic lower_hold;
    logic alarm_cond;
    logic locked;

    always_comb
    begin
        t_s = sx(s_r.temp);
        hy_s = sx(trip_hysteresis_of(s_r.cfg.trip_hysteresis));
        above_crit = t_s >= sx(s_r.crit[12:0]);
        above_upper = t_s > sx(s_r.upper[12:0]);
        below_lower = t_s < sx(s_r.lower[12:0]);
        // hysteresis: once tripped, release only past limit minus offset (lower limit: plus offset)
        crit_hold = t_s >= (sx(s_r.crit[12:0]) - hy_s);
        upper_hold = t_s > (sx(s_r.upper[12:0]) - hy_s);
        lower_hold = t_s < (sx(s_r.lower[12:0]) + hy_s);
        // window outcome that drives the alert
        if (s_r.cfg.crit_only)
        begin
            alarm_cond = above_crit | (s_r.alarm_prev & crit_hold);
        end
        else
        begin
            alarm_cond = above_crit | above_upper | below_lower
                | (s_r.alarm_prev & (crit_hold | upper_hold | lower_hold));
        end
        locked = s_r.cfg.crit_freeze | s_r.cfg.alarm_lock;
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic [15:0] w;
        logic wr_cfg;
        logic clear_req;
        logic asserted;
        w = req_i.wdata;
        wr_cfg = 1'b0;
        clear_req = 1'b0;
        asserted = 1'b0;
        s_nxt = s_r;
        s_nxt.rvalid = 1'b0;

        if (req_i.ptr_wr)
        begin
            s_nxt.ptr = req_i.ptr;
        end

        // --------------------------------------------------------
        // Register writes
        // --------------------------------------------------------
        if (req_i.wr)
        begin
            case (req_i.ptr)
                `TSR_CAP_IDX:
                begin
                    s_nxt.ptr = req_i.ptr;
                end
                `TSR_CFG_IDX:
                begin
                    wr_cfg = 1'b1;
                end
                `TSR_UPPER_IDX:
                begin
                    if (!s_r.cfg.alarm_lock)
                    begin
                        s_nxt.upper = limit_word(w);
                    end
                end
                `TSR_LOWER_IDX:
                begin
                    if (!s_r.cfg.alarm_lock)
                    begin
                        s_nxt.lower = limit_word(w);
                    end
                end
                `TSR_CRIT_IDX:
                begin
                    if (!s_r.cfg.crit_freeze)
                    begin
                        s_nxt.crit = limit_word(w);
                    end
                end
                default:
                begin
                    s_nxt.ptr = req_i.ptr;
                end
            endcase
        end

        // --------------------------------------------------------
        // Configuration
        // --------------------------------------------------------
        if (wr_cfg)
        begin
            // Locks are sticky; only reset clears them
            // critical freeze sticky
            s_nxt.cfg.crit_freeze = s_r.cfg.crit_freeze | w[`CFG_CRIT_LOCK_BIT];
            s_nxt.cfg.alarm_lock = s_r.cfg.alarm_lock | w[`CFG_ALARM_LOCK_BIT];
            if (!locked)
            begin
                s_nxt.cfg.trip_hysteresis = w[`CFG_TRIP_HYSTERESIS_HI:`CFG_TRIP_HYSTERESIS_LO];
                s_nxt.cfg.out_en = w[`CFG_OUT_EN_BIT];
                s_nxt.cfg.polarity = w[`CFG_POL_BIT];
                s_nxt.cfg.intr_mode = w[`CFG_MODE_BIT];
            end
            // set refused under lock, clear always taken
            if (!w[`CFG_PWR_DOWN_BIT] || !locked)
            begin
                s_nxt.cfg.power_down = w[`CFG_PWR_DOWN_BIT];
            end
            if (!w[`CFG_CRIT_ONLY_BIT] || !s_r.cfg.alarm_lock)
            begin
                s_nxt.cfg.crit_only = w[`CFG_CRIT_ONLY_BIT];
            end
            clear_req = w[`CFG_CLEAR_BIT];
        end

        // --------------------------------------------------------
        // Alert event
        // --------------------------------------------------------
        // conversions only while powered up
        if (!s_r.cfg.power_down)
        begin
            if (adc_valid_i)
            begin
                s_nxt.temp = adc_temp_i;
            end
            s_nxt.alarm_prev = alarm_cond;
            // comparator follows, interrupt latches on crossing
            if (!s_r.cfg.intr_mode)
            begin
                s_nxt.cfg.alert_on = alarm_cond;
            end
            else if (alarm_cond != s_r.alarm_prev)
            begin
                s_nxt.cfg.alert_on = 1'b1;
            end
            // clear in interrupt mode unless above critical or a crossing comes in the same cycle
            if (s_r.cfg.intr_mode && clear_req && !above_crit
                && alarm_cond == s_r.alarm_prev)
            begin
                s_nxt.cfg.alert_on = 1'b0;
            end
            if (s_r.cfg.intr_mode && above_crit)
            begin
                s_nxt.cfg.alert_on = 1'b1;
            end
        end
        else
        begin
            // frozen in power-down; clear may drop, never raise
            if (clear_req && s_r.cfg.intr_mode)
            begin
                s_nxt.cfg.alert_on = 1'b0;
            end
        end
        // Entering power-down clears status when capability says so
        if (s_nxt.cfg.power_down && !s_r.cfg.power_down
            && cap_fixed[`CAP_ALERT_PD_BIT])
        begin
            s_nxt.cfg.alert_on = 1'b0;
        end

        // Free-running conversion period marker, kept for pacing visibility
        s_nxt.conv_cnt = (s_r.conv_cnt == 32'(`CONV_CYCLES - 1)) ? 32'h0
            : s_r.conv_cnt + 32'h1;

        // --------------------------------------------------------
        // Read mux
        // --------------------------------------------------------
        if (req_i.rd)
        begin
            case (s_nxt.ptr)
                `TSR_CAP_IDX: s_nxt.rdata = cap_fixed;
                `TSR_CFG_IDX: s_nxt.rdata = cfg_word(s_r.cfg);
                `TSR_UPPER_IDX: s_nxt.rdata = s_r.upper;
                `TSR_LOWER_IDX: s_nxt.rdata = s_r.lower;
                `TSR_CRIT_IDX: s_nxt.rdata = s_r.crit;
                `TSR_TEMP_IDX: s_nxt.rdata = {above_crit, above_upper, below_lower, s_r.temp};
                `TSR_MAKER_IDX: s_nxt.rdata = `TSR_MAKER_VALUE;
                default: s_nxt.rdata = `TSR_PART_VALUE;
            endcase
            s_nxt.rvalid = 1'b1;
        end

        // --------------------------------------------------------
        // Pin drive
        // --------------------------------------------------------
        // disabled output inactive; polarity sets level
        asserted = s_nxt.cfg.alert_on & s_nxt.cfg.out_en;
        if (s_nxt.cfg.polarity)
        begin
            s_nxt.alert_pin = asserted;
            s_nxt.alert_oe_n = 1'b0;
        end
        else
        begin
            s_nxt.alert_pin = 1'b0;
            s_nxt.alert_oe_n = !asserted;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            s_r <= '0;
            s_r.ptr <= `TSR_CAP_IDX;
            s_r.alert_oe_n <= 1'b1;
            s_r.temp <= `TSR_TEMP_RESET;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign rdata_o = s_r.rdata;
    assign rvalid_o = s_r.rvalid;
    assign ptr_o = s_r.ptr;
    assign alert_o = s_r.alert_pin;
    assign alert_oe_n_o = s_r.alert_oe_n;

endmodule // thermal_sensor_register_bank

`default_nettype wire

/* sim/thermal_sensor_register_bank_properties.sv */
`include "thermal_sensor_cfg.svh"
`default_nettype none
// ----
// Port checks
// ----
module thermal_sensor_register_bank_properties (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // Inputs
    input wire thermal_sensor_pkg::reg_req_t req_i,
    input wire logic [12:0] adc_temp_i,
    input wire logic adc_valid_i,
    // Outputs
    input wire logic [15:0] rdata_o,
    input wire logic rvalid_o,
    input wire logic [2:0] ptr_o,
    input wire logic alert_o,
    input wire logic alert_oe_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] rd_ptr;
    // A read with a pointer move in the same cycle sees the new pointer
    assign rd_ptr = req_i.ptr_wr ? req_i.ptr : ptr_o;
    default clocking @(posedge ref_clk_i);
    endclocking
    default disable iff (sys_rst_i);
    sequence s_rd(logic [2:0] idx);
        req_i.rd && rd_ptr == idx;
    endsequence
    sequence s_quiet;
        !req_i.wr && !adc_valid_i;
    endsequence
    a_read_answer: assert property (req_i.rd |=> rvalid_o)
        else $error("read not answered");
    a_rdata_hold: assert property (!req_i.rd |=> $stable(rdata_o))
        else $error("read data moved");
    a_ptr_select: assert property (req_i.ptr_wr |=> ptr_o == $past(req_i.ptr))
        else $error("pointer not set");
    a_cap_fixed: assert property (s_rd(`TSR_CAP_IDX) |=> rdata_o == `TSR_CAP_VALUE)
        else $error("capability wrong");
    a_limit_format: assert property (req_i.rd && rd_ptr inside {[3'h2:3'h4]} |=>
        rdata_o[15:13] == 3'h0 && rdata_o[1:0] == 2'h0)
        else $error("limit format wrong");
    a_pin_level: assert property (!(alert_o && alert_oe_n_o))
        else $error("released pin driven high");
    a_start_quiet: assert property ($fell(sys_rst_i) |-> alert_oe_n_o && !alert_o)
        else $error("alert active after reset");
    // Pins move only within two cycles after a write or a sample
    a_alert_cause: assert property (s_quiet ##1 s_quiet |=>
        $stable(alert_o) && $stable(alert_oe_n_o))
        else $error("alert moved without cause");
endmodule // thermal_sensor_register_bank_properties

bind thermal_sensor_register_bank thermal_sensor_register_bank_properties i_props (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .req_i(req_i),
    .adc_temp_i(adc_temp_i), .adc_valid_i(adc_valid_i), .rdata_o(rdata_o),
    .rvalid_o(rvalid_o), .ptr_o(ptr_o), .alert_o(alert_o), .alert_oe_n_o(alert_oe_n_o)
);
`default_nettype wire

/* sim/host_master_model.sv */
`default_nettype none
// ----
// Host master
// ----
module host_master_model (
    // Clock
    input wire logic ref_clk_i,
    // Answer
    input wire logic [15:0] rdata_i,
    input wire logic rvalid_i,
    // Request
    output var thermal_sensor_pkg::reg_req_t req_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial req_o = '0;
    // Released fields show inverted values, so nothing stale looks valid
    task automatic idle();
        req_o = '{1'b0, 1'b0, 1'b0, ~req_o.ptr, ~req_o.wdata};
    endtask
    task automatic wr(input logic [2:0] idx, input logic [15:0] d);
        @(negedge ref_clk_i);
        req_o = '{1'b1, 1'b0, 1'b1, idx, d};
        @(negedge ref_clk_i);
        idle();
    endtask
    task automatic rd(input logic [2:0] idx, output logic [15:0] d, output logic v);
        @(negedge ref_clk_i);
        req_o = '{1'b0, 1'b1, 1'b1, idx, ~req_o.wdata};
        @(negedge ref_clk_i);
        d = rdata_i;
        v = rvalid_i;
        idle();
    endtask
endmodule // host_master_model
`default_nettype wire

/* sim/thermal_sensor_register_bank_tb.sv */
`include "thermal_sensor_cfg.svh"
`default_nettype none
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin fails++; \
    $display("FAIL %s expected %h seen %h", n, e, s); end end
// ----
// Bench
// ----
module thermal_sensor_register_bank_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [12:0] adc_temp_i = 13'h0000;
    logic adc_valid_i = 1'b0;
    thermal_sensor_pkg::reg_req_t req_i;
    logic [15:0] rdata_o;
    logic rvalid_o;
    logic [2:0] ptr_o;
    logic alert_o;
    logic alert_oe_n_o;
    int fails = 0;
    int total_checks = 0;
    logic [31:0] seed = 32'hc32a68e7;
    logic [31:0] r;
    logic [12:0] t;
    logic [12:0] lim [8] = '{default: 13'h0000};
    logic [15:0] rst_tab [8] = '{`TSR_CAP_VALUE, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
        16'h8000, `TSR_MAKER_VALUE, `TSR_PART_VALUE};
    logic [12:0] hy [4] = '{`TRIP_HYSTERESIS_0, `TRIP_HYSTERESIS_1, `TRIP_HYSTERESIS_2, `TRIP_HYSTERESIS_3};

    thermal_sensor_register_bank i_dut (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .req_i(req_i),
        .adc_temp_i(adc_temp_i), .adc_valid_i(adc_valid_i), .rdata_o(rdata_o),
        .rvalid_o(rvalid_o), .ptr_o(ptr_o), .alert_o(alert_o), .alert_oe_n_o(alert_oe_n_o)
    );
    host_master_model i_host (
        .ref_clk_i(ref_clk_i), .rdata_i(rdata_o), .rvalid_i(rvalid_o), .req_o(req_i)
    );

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Temperature and limits share bit weights, so flags compare words directly
    function automatic logic [15:0] t_word(input logic [12:0] v);
        return {$signed(v) >= $signed(lim[4]), $signed(v) > $signed(lim[2]),
            $signed(v) < $signed(lim[3]), v};
    endfunction
    task automatic rc(input logic [2:0] i, input logic [15:0] e, input string n);
        logic [15:0] v;
        logic ok;
        i_host.rd(i, v, ok);
        `CHK(n, 1'b1, ok)
        `CHK(n, e, v)
    endtask
    task automatic wlim(input logic [2:0] i, input logic [15:0] v);
        i_host.wr(i, v);
        lim[i] = v[12:0] & 13'h1ffc;
    endtask
    task automatic cfg(input logic [15:0] v);
        i_host.wr(3'h1, v);
    endtask
    task automatic tset(input logic [12:0] v);
        @(negedge ref_clk_i);
        adc_temp_i = v;
        adc_valid_i = 1'b1;
        @(negedge ref_clk_i);
        adc_valid_i = 1'b0;
    endtask
    task automatic pins(input logic oe, input logic a);
        repeat (2) @(negedge ref_clk_i);
        `CHK("alert_oe_n", oe, alert_oe_n_o)
        `CHK("alert", a, alert_o)
    endtask
    task automatic done(input string n);
        $display("test %s done", n);
    endtask
    task automatic end_of_test();
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end
    initial
    begin
        repeat (20000) @(posedge ref_clk_i);
        fails++;
        end_of_test();
    end
    initial
    begin
        repeat (8) @(negedge ref_clk_i);
        sys_rst_i = 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            if (i == 0 || i > 4)
                i_host.wr(3'(i), ~rst_tab[i]);
            rc(3'(i), rst_tab[i], "reset value");
        end
        done("registers");
        for (int k = 0; k < 18; k++)
        begin
            for (int j = 2; j < 5; j++)
            begin
                r = xs();
                wlim(3'(j), r[15:0]);
                rc(3'(j), {3'h0, lim[j]}, "limit");
            end
            r = xs();
            t = k == 16 ? lim[4] : k == 17 ? lim[2] : r[12:0];
            tset(t);
            rc(3'h5, t_word(t), "temperature");
        end
        cfg(16'h0100);
        tset(~t);
        rc(3'h5, t_word(t), "frozen");
        cfg(16'h0000);
        tset(~t);
        rc(3'h5, t_word(~t), "running");
        done("temperature");
        wlim(3'h2, 16'h0320);
        wlim(3'h3, 16'h0000);
        wlim(3'h4, 16'h0640);
        tset(13'h0400);
        cfg(16'h0008);
        pins(1'b0, 1'b0);
        rc(3'h1, 16'h0018, "alert copy");
        cfg(16'h000a);
        pins(1'b0, 1'b1);
        cfg(16'h0002);
        pins(1'b0, 1'b0);
        cfg(16'h0000);
        pins(1'b1, 1'b0);
        cfg(16'h0028);
        pins(1'b0, 1'b0);
        for (int h = 0; h < 4; h++)
        begin
            cfg(16'h0008 | 16'(h << 9));
            tset(13'h0330);
            pins(1'b0, 1'b0);
            tset(13'h0320 - hy[h] / 2);
            pins(h == 0, 1'b0);
            tset(13'h0320 - hy[h] - 13'h0010);
            pins(1'b1, 1'b0);
        end
        cfg(16'h000c);
        tset(13'h0400);
        pins(1'b1, 1'b0);
        tset(13'h0700);
        pins(1'b0, 1'b0);
        rc(3'h1, 16'h001c, "critical only");
        tset(13'h0100);
        pins(1'b1, 1'b0);
        done("comparator");
        cfg(16'h0029);
        pins(1'b1, 1'b0);
        tset(13'h0400);
        tset(13'h0100);
        pins(1'b0, 1'b0);
        cfg(16'h0029);
        pins(1'b1, 1'b0);
        rc(3'h1, 16'h0009, "clear bit");
        tset(13'h0700);
        cfg(16'h0029);
        pins(1'b0, 1'b0);
        done("interrupt");
        cfg(16'h0080);
        i_host.wr(3'h4, 16'h0100);
        rc(3'h4, {3'h0, lim[4]}, "critical locked");
        cfg(16'h00c0);
        cfg(16'h01cf);
        rc(3'h1, 16'h00c0, "locked fields");
        cfg(16'h0000);
        rc(3'h1, 16'h00c0, "locks hold");
        i_host.wr(3'h2, 16'h0100);
        rc(3'h2, {3'h0, lim[2]}, "alarm locked");
        sys_rst_i = 1'b1;
        repeat (8) @(negedge ref_clk_i);
        sys_rst_i = 1'b0;
        rc(3'h1, 16'h0000, "locks cleared");
        wlim(3'h4, 16'h0100);
        rc(3'h4, 16'h0100, "critical free");
        done("locks");
        end_of_test();
    end
endmodule // thermal_sensor_register_bank_tb
`default_nettype wire
